// file: pcd_pkg.sv
// Constants and types shared by the pressure change detector
package pcd_pkg;
	localparam int SW = 16;
	localparam int CW = 8;
	localparam int NW = 23;
	localparam int DVW = 17;
	localparam int SLOPE_SH = 7;
	localparam logic [4:0] OFS_CFG = 5'h00;
	localparam logic [4:0] OFS_FIX = 5'h04;
	localparam logic [4:0] OFS_REL = 5'h08;
	localparam logic [4:0] OFS_MIN = 5'h0c;
	localparam logic [4:0] OFS_DEB = 5'h10;
	localparam logic [4:0] OFS_SLP = 5'h14;
	localparam logic [4:0] OFS_STAT = 5'h18;
	localparam logic [4:0] OFS_SAMP = 5'h1c;
	localparam int CFG_FIX_BIT = 0;
	localparam int CFG_REL_BIT = 1;
	localparam int CFG_SLP_BIT = 2;
	localparam int ST_FIX_BIT = 0;
	localparam int ST_REL_BIT = 1;
	localparam int ST_SLP_BIT = 2;
	localparam int ST_EVT_BIT = 3;
	localparam logic [2:0] CFG_RST = 3'h0;
	localparam logic [15:0] TH_RST = 16'h0000;
	localparam logic [7:0] B_RST = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [15:0] PERIOD_MAX = 16'hffff;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_EVAL = 3'b001,
		S_FLAG = 3'b010,
		S_DIV = 3'b011,
		S_DONE = 3'b100
	} seq_state_e;
endpackage

// file: sat_counter.sv
// Saturating up/down debounce counter
`timescale 1ns/1ps
module sat_counter (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clr,
	input wire logic step,
	input wire logic up,
	output logic [pcd_pkg::CW-1:0] count
);
	// Count once per step, holding at both ends
	always_ff @(posedge clk_sys)
	begin
		if (srst || clr)
			count <= '0;
		else if (step && up && count != pcd_pkg::CNT_MAX)
			count <= count + pcd_pkg::CW'(1);
		else if (step && !up && count != '0)
			count <= count - pcd_pkg::CW'(1);
	end

	sat_floor_a: assert property (@(posedge clk_sys) disable iff (srst)
		(step && !up && !clr && count == '0) |=> count == '0)
		else $error("counter went below zero");
endmodule // sat_counter

// file: slope_divider.sv
// Restoring divider for the scaled pressure slope
`timescale 1ns/1ps
module slope_divider (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic start,
	input wire logic [pcd_pkg::NW-1:0] dividend,
	input wire logic [pcd_pkg::DVW-1:0] divisor,
	output logic done,
	output logic [pcd_pkg::NW-1:0] quotient
);
	logic [pcd_pkg::DVW-1:0] rem_r;
	logic [pcd_pkg::DVW-1:0] dvs_r;
	logic [4:0] left_r;
	logic [pcd_pkg::DVW:0] trial;
	logic fits;

	// Shift in one dividend bit and try the subtraction
	always_comb
	begin
		trial = {rem_r, quotient[pcd_pkg::NW-1]};
		fits = trial >= {1'b0, dvs_r};
	end

	// One quotient bit per cycle, done pulses with the last bit
	always_ff @(posedge clk_sys)
	begin
		done <= 1'b0;
		if (srst)
		begin
			rem_r <= '0;
			dvs_r <= '0;
			left_r <= '0;
			quotient <= '0;
		end
		else if (start)
		begin
			rem_r <= '0;
			dvs_r <= divisor;
			left_r <= 5'(pcd_pkg::NW);
			quotient <= dividend;
		end
		else if (left_r != '0)
		begin
			rem_r <= fits ? pcd_pkg::DVW'(trial - {1'b0, dvs_r})
				: trial[pcd_pkg::DVW-1:0];
			quotient <= {quotient[pcd_pkg::NW-2:0], fits};
			left_r <= left_r - 5'h01;
			done <= left_r == 5'h01;
		end
	end
endmodule // slope_divider

// file: pcd_core.sv
// Pressure change detector with Avalon-MM register access
`timescale 1ns/1ps
module pcd_core (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic sample_valid,
	input wire logic [pcd_pkg::SW-1:0] sample_data,
	output logic fixed_change_flag,
	output logic relative_change_flag,
	output logic slope_change_flag,
	output logic event_pending_flag
);
	pcd_pkg::seq_state_e state_r;
	pcd_pkg::seq_state_e state_nxt;
	logic [2:0] change_detect_config;
	logic [15:0] fixed_threshold_regs, relative_threshold_regs;
	logic [15:0] slope_threshold_regs;
	logic [7:0] minimum_step_reg, debounce_limit_reg;
	logic [15:0] cur_r, prev_r, rref_r, sref_r;
	logic [15:0] period_r, period_nxt;
	logic [7:0] fixed_debounce_counter, rise_counter;
	logic [7:0] relative_debounce_counter, slope_debounce_counter;
	logic [31:0] rd_nxt;
	logic [22:0] slope_num, slope_val;
	logic [16:0] slope_den;
	logic fixed_option_enable, relative_option_enable, slope_option_enable;
	logic wr_acc, rising, rel_over, fix_over, slope_reset, go_div, div_done;
	logic [3:0] stat_clr;

	assign fixed_option_enable = change_detect_config[pcd_pkg::CFG_FIX_BIT];
	assign relative_option_enable = change_detect_config[pcd_pkg::CFG_REL_BIT];
	assign slope_option_enable = change_detect_config[pcd_pkg::CFG_SLP_BIT];

	// ----------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------

	// Bus answers one cycle after a request appears
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			waitrequest <= 1'b1;
		else
			waitrequest <= !((read || write) && waitrequest);
	end

	assign wr_acc = write && !waitrequest;
	assign stat_clr = (wr_acc && address == pcd_pkg::OFS_STAT && byteenable[0])
		? writedata[3:0] : 4'h0;

	// Read mux, unmapped offsets read zero
	always_comb
	begin
		rd_nxt = 32'h0;
		case (address)
			pcd_pkg::OFS_CFG: rd_nxt[2:0] = change_detect_config;
			pcd_pkg::OFS_FIX: rd_nxt[15:0] = fixed_threshold_regs;
			pcd_pkg::OFS_REL: rd_nxt[15:0] = relative_threshold_regs;
			pcd_pkg::OFS_MIN: rd_nxt[7:0] = minimum_step_reg;
			pcd_pkg::OFS_DEB: rd_nxt[7:0] = debounce_limit_reg;
			pcd_pkg::OFS_SLP: rd_nxt[15:0] = slope_threshold_regs;
			pcd_pkg::OFS_STAT: rd_nxt[3:0] = {event_pending_flag,
				slope_change_flag, relative_change_flag, fixed_change_flag};
			pcd_pkg::OFS_SAMP: rd_nxt[15:0] = prev_r;
			default: rd_nxt = 32'h0;
		endcase
	end

	// Read data is loaded as waitrequest drops
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			readdata <= 32'h0;
		else if (read && waitrequest)
			readdata <= rd_nxt;
	end

	// Configuration registers with byte lanes
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			change_detect_config <= pcd_pkg::CFG_RST;
			fixed_threshold_regs <= pcd_pkg::TH_RST;
			relative_threshold_regs <= pcd_pkg::TH_RST;
			slope_threshold_regs <= pcd_pkg::TH_RST;
			minimum_step_reg <= pcd_pkg::B_RST;
			debounce_limit_reg <= pcd_pkg::B_RST;
		end
		else if (wr_acc)
		begin
			case (address)
				pcd_pkg::OFS_CFG:
					if (byteenable[0])
						change_detect_config <= writedata[2:0];
				pcd_pkg::OFS_FIX:
				begin
					if (byteenable[0])
						fixed_threshold_regs[7:0] <= writedata[7:0];
					if (byteenable[1])
						fixed_threshold_regs[15:8] <= writedata[15:8];
				end
				pcd_pkg::OFS_REL:
				begin
					if (byteenable[0])
						relative_threshold_regs[7:0] <= writedata[7:0];
					if (byteenable[1])
						relative_threshold_regs[15:8] <= writedata[15:8];
				end
				pcd_pkg::OFS_SLP:
				begin
					if (byteenable[0])
						slope_threshold_regs[7:0] <= writedata[7:0];
					if (byteenable[1])
						slope_threshold_regs[15:8] <= writedata[15:8];
				end
				pcd_pkg::OFS_MIN:
					if (byteenable[0])
						minimum_step_reg <= writedata[7:0];
				pcd_pkg::OFS_DEB:
					if (byteenable[0])
						debounce_limit_reg <= writedata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------
	// Sample sequencer
	// ----------------------------------------------------------

	// Comparisons on the captured sample, all strict and unsigned
	always_comb
	begin
		rising = {1'b0, cur_r}
			> ({1'b0, prev_r} + {9'h0, minimum_step_reg});
		fix_over = cur_r > fixed_threshold_regs;
		rel_over = (cur_r > rref_r)
			&& ((cur_r - rref_r) > relative_threshold_regs);
		slope_num = (cur_r > sref_r)
			? {cur_r - sref_r, 7'h0} : 23'h0;
		slope_reset = period_r == pcd_pkg::PERIOD_MAX;
		period_nxt = (slope_debounce_counter == '0 || slope_reset)
			? 16'h0 : period_r + 16'h1;
		slope_den = {1'b0, period_nxt} + 17'h1;
		go_div = slope_option_enable && !slope_reset
			&& slope_debounce_counter > debounce_limit_reg;
	end

	// Next step of the per-sample evaluation
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			pcd_pkg::S_IDLE:
				if (sample_valid)
					state_nxt = pcd_pkg::S_EVAL;
			pcd_pkg::S_EVAL: state_nxt = pcd_pkg::S_FLAG;
			pcd_pkg::S_FLAG:
				state_nxt = go_div ? pcd_pkg::S_DIV : pcd_pkg::S_DONE;
			pcd_pkg::S_DIV:
				if (div_done)
					state_nxt = pcd_pkg::S_DONE;
			pcd_pkg::S_DONE: state_nxt = pcd_pkg::S_IDLE;
			default: state_nxt = pcd_pkg::S_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			state_r <= pcd_pkg::S_IDLE;
		else
			state_r <= state_nxt;
	end

	// Sample capture and previous-sample update
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cur_r <= '0;
			prev_r <= '0;
		end
		else if (state_r == pcd_pkg::S_IDLE && sample_valid)
			cur_r <= sample_data;
		else if (state_r == pcd_pkg::S_DONE)
			prev_r <= cur_r;
	end

	// ----------------------------------------------------------
	// Debounce counters
	// ----------------------------------------------------------

	sat_counter u_fix_cnt (
		.clk_sys(clk_sys),
		.srst(srst),
		.clr(1'b0),
		.step(state_r == pcd_pkg::S_EVAL && fixed_option_enable),
		.up(fix_over),
		.count(fixed_debounce_counter)
	);
	sat_counter u_rise_cnt (
		.clk_sys(clk_sys),
		.srst(srst),
		.clr(1'b0),
		.step(state_r == pcd_pkg::S_EVAL && relative_option_enable),
		.up(rising),
		.count(rise_counter)
	);
	sat_counter u_rel_cnt (
		.clk_sys(clk_sys),
		.srst(srst),
		.clr(1'b0),
		.step(state_r == pcd_pkg::S_EVAL && relative_option_enable
			&& rising),
		.up(rel_over),
		.count(relative_debounce_counter)
	);
	sat_counter u_slope_cnt (
		.clk_sys(clk_sys),
		.srst(srst),
		.clr(state_r == pcd_pkg::S_FLAG && slope_option_enable
			&& slope_reset),
		.step(state_r == pcd_pkg::S_EVAL && slope_option_enable),
		.up(rising),
		.count(slope_debounce_counter)
	);

	// Reference follows pressure on the stepped counts, so it keeps the
	// last sample before a rise began
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			rref_r <= '0;
		else if (state_r == pcd_pkg::S_FLAG && relative_option_enable
			&& relative_debounce_counter == '0 && rise_counter == '0)
			rref_r <= cur_r;
	end

	// Slope reference and elapsed-period counter
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			sref_r <= '0;
			period_r <= '0;
		end
		else if (state_r == pcd_pkg::S_FLAG && slope_option_enable)
		begin
			period_r <= period_nxt;
			if (slope_debounce_counter == '0 || slope_reset)
				sref_r <= cur_r;
		end
	end

	slope_divider u_div (
		.clk_sys(clk_sys),
		.srst(srst),
		.start(state_r == pcd_pkg::S_FLAG && go_div),
		.dividend(slope_num),
		.divisor(slope_den),
		.done(div_done),
		.quotient(slope_val)
	);

	// ----------------------------------------------------------
	// Status flags, set wins over a clear in the same cycle
	// ----------------------------------------------------------

	// Change flags, write one to clear
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			fixed_change_flag <= 1'b0;
			relative_change_flag <= 1'b0;
			slope_change_flag <= 1'b0;
		end
		else
		begin
			fixed_change_flag <= (state_r == pcd_pkg::S_FLAG
				&& fixed_option_enable
				&& fixed_debounce_counter > debounce_limit_reg)
				|| (fixed_change_flag && !stat_clr[pcd_pkg::ST_FIX_BIT]);
			relative_change_flag <= (state_r == pcd_pkg::S_FLAG
				&& relative_option_enable
				&& relative_debounce_counter > debounce_limit_reg)
				|| (relative_change_flag && !stat_clr[pcd_pkg::ST_REL_BIT]);
			slope_change_flag <= (state_r == pcd_pkg::S_DIV && div_done
				&& slope_val > {7'h0, slope_threshold_regs})
				|| (slope_change_flag && !stat_clr[pcd_pkg::ST_SLP_BIT]);
		end
	end

	// Host notice once all options have run
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			event_pending_flag <= 1'b0;
		else
			event_pending_flag <= (state_r == pcd_pkg::S_DONE
				&& (fixed_change_flag || relative_change_flag
				|| slope_change_flag))
				|| (event_pending_flag && !stat_clr[pcd_pkg::ST_EVT_BIT]);
	end

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	sequence sample_taken_s;
		state_r == pcd_pkg::S_IDLE && sample_valid;
	endsequence
	sequence eval_flag_s;
		state_r == pcd_pkg::S_EVAL ##1 state_r == pcd_pkg::S_FLAG;
	endsequence
	sample_path_a: assert property (sample_taken_s |=> eval_flag_s)
		else $error("sample not evaluated in order");
	fix_gate_a: assert property ((state_r == pcd_pkg::S_EVAL
		&& !fixed_option_enable) |=> $stable(fixed_debounce_counter))
		else $error("fixed counter moved while disabled");
	fix_count_a: assert property ((state_r == pcd_pkg::S_EVAL
		&& fixed_option_enable && fix_over
		&& fixed_debounce_counter != pcd_pkg::CNT_MAX)
		|=> fixed_debounce_counter == $past(fixed_debounce_counter) + 8'h01)
		else $error("fixed counter did not count up");
	fix_flag_a: assert property ((state_r == pcd_pkg::S_FLAG
		&& fixed_option_enable
		&& fixed_debounce_counter > debounce_limit_reg) |=> fixed_change_flag)
		else $error("fixed flag not raised");
	rel_flag_a: assert property ((state_r == pcd_pkg::S_FLAG
		&& relative_option_enable
		&& relative_debounce_counter > debounce_limit_reg)
		|=> relative_change_flag)
		else $error("relative flag not raised");
	rel_ref_a: assert property ((state_r == pcd_pkg::S_FLAG
		&& relative_option_enable && relative_debounce_counter == '0
		&& rise_counter == '0) |=> rref_r == $past(cur_r))
		else $error("relative reference not loaded");
	period_wrap_a: assert property ((state_r == pcd_pkg::S_FLAG
		&& slope_option_enable && slope_reset)
		|=> period_r == 16'h0 && slope_debounce_counter == '0)
		else $error("period counter not restarted");
	slope_flag_a: assert property ((state_r == pcd_pkg::S_DIV && div_done
		&& slope_val > {7'h0, slope_threshold_regs}) |=> slope_change_flag)
		else $error("slope flag not raised");
	event_flag_a: assert property ((state_r == pcd_pkg::S_DONE
		&& (fixed_change_flag || relative_change_flag
		|| slope_change_flag)) |=> event_pending_flag)
		else $error("event flag not raised");
	prev_upd_a: assert property (state_r == pcd_pkg::S_DONE
		|=> prev_r == $past(cur_r) && state_r == pcd_pkg::S_IDLE)
		else $error("previous sample not updated");
endmodule // pcd_core

// file: host_model.sv
// Host side model: Avalon-MM master that reads and clears status
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys,
	input wire logic waitrequest,
	input wire logic [31:0] readdata,
	output logic [4:0] address,
	output logic read,
	output logic write,
	output logic [3:0] byteenable,
	output logic [31:0] writedata
);
	// -----------------------------------------
	// Idle bus at time zero
	// -----------------------------------------
	initial
	begin
		address = 5'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hf;
		writedata = 32'h00000000;
	end

	// One transfer: hold request until waitrequest is seen low at an edge
	task automatic bus_xfer(input logic wr, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0)
		begin
			@(posedge clk_sys);
		end
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule // host_model

// file: pressure_change_detector_tb.sv
// Self-checking bench for the pressure change detector
`timescale 1ns/1ps
module pressure_change_detector_tb;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [4:0] address;
	logic read;
	logic write;
	logic [3:0] byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic sample_valid = 1'b0;
	logic [15:0] sample_data = 16'h0000;
	logic fixed_change_flag;
	logic relative_change_flag;
	logic slope_change_flag;
	logic event_pending_flag;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'hedde;
	logic [7:0] fc, rc, ic, sc, deb;
	logic [15:0] prv, rref, sref, per, smp;
	logic [3:0] st;
	logic [31:0] q;
	localparam logic [15:0] FTH = 16'h1010;
	localparam logic [15:0] RTH = 16'h0020;
	localparam logic [15:0] STH = 16'h0180;
	localparam logic [7:0] MINS = 8'h02;

	// -----------------------------------------
	// Clock, design and host
	// -----------------------------------------
	always #2.5 clk_sys = ~clk_sys;

	pcd_core dut (.clk_sys(clk_sys), .srst(srst), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sample_valid(sample_valid),
		.sample_data(sample_data), .fixed_change_flag(fixed_change_flag),
		.relative_change_flag(relative_change_flag),
		.slope_change_flag(slope_change_flag),
		.event_pending_flag(event_pending_flag));

	host_model host (.clk_sys(clk_sys), .waitrequest(waitrequest),
		.readdata(readdata), .address(address), .read(read),
		.write(write), .byteenable(byteenable), .writedata(writedata));

	// -----------------------------------------
	// Helpers
	// -----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Saturating step of a debounce count
	function automatic logic [7:0] upd(input logic [7:0] c, input logic u);
		if (u)
			return (c == 8'hff) ? c : c + 8'h01;
		return (c == 8'h00) ? c : c - 8'h01;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Expected state after one sample under configuration cfg
	task automatic model(input logic [15:0] s, input logic [2:0] cfg);
		logic rise;
		int slope;
		rise = {1'b0, s} > ({1'b0, prv} + {9'h000, MINS});
		if (cfg[0])
			fc = upd(fc, s > FTH);
		if (cfg[1])
		begin
			ic = upd(ic, rise);
			if (rise)
				rc = upd(rc, {1'b0, s} > {1'b0, rref} + {1'b0, RTH});
			if (rc == 8'h00 && ic == 8'h00)
				rref = s;
		end
		if (cfg[2])
		begin
			sc = upd(sc, rise);
			if (sc == 8'h00)
			begin
				per = 16'h0000;
				sref = s;
			end
			else
			begin
				per = per + 16'h0001;
				if (sc > deb && s > sref)
				begin
					slope = (int'(s - sref) * 128) / (int'(per) + 1);
					st[2] = st[2] | (slope > int'(STH));
				end
			end
		end
		st[0] = st[0] | (fc > deb);
		st[1] = st[1] | (rc > deb);
		st[3] = st[3] | (|st[2:0]);
		prv = s;
	endtask

	// -----------------------------------------
	// Watchdog
	// -----------------------------------------
	initial
	begin
		// A full run takes about 11000 cycles; allow near three times that
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		end_of_test();
	end

	// -----------------------------------------
	// Main sequence: every option mix, random rising walk
	// -----------------------------------------
	initial
	begin
		for (int cfg = 0; cfg < 8; cfg++)
		begin
			@(posedge clk_sys);
			srst <= 1'b1;
			repeat (10) @(posedge clk_sys);
			srst <= 1'b0;
			{fc, rc, ic, sc} = 32'h00000000;
			{prv, rref, sref, per} = 64'h0;
			st = 4'h0;
			deb = cfg[0] ? 8'h00 : 8'h03; // Limit of zero is a corner
			host.bus_xfer(1'b0, pcd_pkg::OFS_STAT, 32'h0, q);
			chk(q, 32'h00000000);
			host.bus_xfer(1'b0, 5'h1e, 32'h0, q);
			chk(q, 32'h00000000);
			host.bus_xfer(1'b1, pcd_pkg::OFS_CFG, cfg, q);
			host.bus_xfer(1'b1, pcd_pkg::OFS_FIX, {16'h0, FTH}, q);
			host.bus_xfer(1'b1, pcd_pkg::OFS_REL, {16'h0, RTH}, q);
			host.bus_xfer(1'b1, pcd_pkg::OFS_MIN, {24'h0, MINS}, q);
			host.bus_xfer(1'b1, pcd_pkg::OFS_DEB, {24'h0, deb}, q);
			host.bus_xfer(1'b1, pcd_pkg::OFS_SLP, {16'h0, STH}, q);
			host.bus_xfer(1'b0, pcd_pkg::OFS_CFG, 32'h0, q);
			chk(q, cfg);
			host.bus_xfer(1'b0, pcd_pkg::OFS_SLP, 32'h0, q);
			chk(q, {16'h0, STH});
			smp = 16'h1000;
			for (int n = 0; n < 28; n++)
			begin
				seed = lfsr(seed);
				smp = smp + {12'h000, seed[3:0]} - 16'h0005;
				if (n == 14)
					smp = 16'h0f00; // Sharp fall drains counters
				@(posedge clk_sys);
				sample_valid <= 1'b1;
				sample_data <= smp;
				@(posedge clk_sys);
				sample_valid <= 1'b0;
				repeat (40) @(posedge clk_sys);
				model(smp, cfg[2:0]);
				chk({28'h0, event_pending_flag, slope_change_flag,
					relative_change_flag, fixed_change_flag}, st);
				host.bus_xfer(1'b0, pcd_pkg::OFS_SAMP, 32'h0, q);
				chk(q, {16'h0, smp});
				if (n % 6 == 5)
				begin
					host.bus_xfer(1'b1, pcd_pkg::OFS_STAT, 32'hf, q);
					st = 4'h0;
					host.bus_xfer(1'b0, pcd_pkg::OFS_STAT, 32'h0, q);
					chk(q, 32'h00000000);
				end
			end
		end
		end_of_test();
	end
endmodule // pressure_change_detector_tb
